// >>> core/fsbc_pkg.sv
// constants, enumerations and carriers of the fan and sensor bus command block
// assumes one 10 MHz clock and whole command packets already framed and checked
package fsbc_pkg;

   // ==========================================================
   // command and reply codes
   localparam logic [7:0] FSBC_CMD_STORE    = 8'h04;
   localparam logic [7:0] FSBC_CMD_FAN_RPT  = 8'h10;
   localparam logic [7:0] FSBC_CMD_FAN_PWR  = 8'h11;
   localparam logic [7:0] FSBC_CMD_DEV_INFO = 8'h12;
   localparam logic [7:0] FSBC_CMD_TEMP_RPT = 8'h13;
   localparam logic [7:0] FSBC_CMD_XACT     = 8'h14;
   localparam logic [7:0] FSBC_ACK_BIT      = 8'h40;
   localparam logic [7:0] FSBC_ERR_BITS     = 8'hc0;
   localparam logic [7:0] FSBC_FAN_REPORT   = 8'h81;
   localparam logic [7:0] FSBC_MATCH_CMD    = 8'h55;

   // ==========================================================
   // field limits and lengths
   localparam logic [7:0] FSBC_FAN_MASK_MAX = 8'h0f;
   localparam logic [7:0] FSBC_LEVEL_MAX    = 8'h64;
   localparam logic [6:0] FSBC_LEVEL_FULL   = 7'h64;
   localparam logic [7:0] FSBC_IDX_MAX      = 8'h1f;
   localparam logic [7:0] FSBC_IDX_SKIP     = 8'h20;
   localparam logic [7:0] FSBC_RCNT_MAX     = 8'h0e;
   localparam logic [4:0] FSBC_LEN_ZERO     = 5'h00;
   localparam logic [4:0] FSBC_LEN_ONE      = 5'h01;
   localparam logic [4:0] FSBC_LEN_FOUR     = 5'h04;
   localparam logic [4:0] FSBC_LEN_INFO     = 5'h09;
   localparam logic [4:0] FSBC_LEN_FAN_RSP  = 5'h03;
   localparam logic [4:0] FSBC_XACT_MIN     = 5'h02;
   localparam logic [4:0] FSBC_XACT_MAX     = 5'h10;
   localparam int         FSBC_FANS         = 4;

   // ==========================================================
   // timing
   localparam int FSBC_CLK_KHZ   = 10000;
   localparam int FSBC_PERIOD_MS = 500;
   localparam int FSBC_SLOT_MS   = 125;
   localparam int FSBC_SLOT_CYC  = FSBC_SLOT_MS * FSBC_CLK_KHZ;
   localparam int FSBC_TICK_W    = 24;

   // ==========================================================
   // register map and event bits
   localparam logic [3:0] FSBC_REG_STATUS  = 4'h0;
   localparam logic [3:0] FSBC_REG_IRQ_EN  = 4'h4;
   localparam logic [3:0] FSBC_REG_IRQ_CLR = 4'h8;
   localparam logic [3:0] FSBC_REG_INFO    = 4'hc;
   localparam int         FSBC_EV_CMD      = 0;
   localparam int         FSBC_EV_ENUM     = 1;
   localparam int         FSBC_EV_RPT      = 2;
   localparam int         FSBC_EV_BAD      = 3;

   // ==========================================================
   // types
   typedef enum logic [2:0] {
      FSBC_OP_RESET = 3'h0,
      FSBC_OP_WRITE = 3'h1,
      FSBC_OP_READ  = 3'h2,
      FSBC_OP_FIRST = 3'h3,
      FSBC_OP_NEXT  = 3'h4
   } fsbc_op_t;

   typedef enum logic [6:0] {
      FSBC_S_INIT = 7'h01,
      FSBC_S_ENUM = 7'h02,
      FSBC_S_IDLE = 7'h04,
      FSBC_S_XRST = 7'h08,
      FSBC_S_XADR = 7'h10,
      FSBC_S_XWR  = 7'h20,
      FSBC_S_XRD  = 7'h40
   } fsbc_state_t;

   typedef struct packed {
      logic [7:0]        ctype;
      logic [4:0]        len;
      logic [15:0][7:0]  data;
   } fsbc_cmd_t;

   typedef struct packed {
      logic [7:0]        rtype;
      logic [4:0]        len;
      logic [13:0][7:0]  data;
   } fsbc_rsp_t;

   typedef struct packed {
      logic              req;
      fsbc_op_t          op;
      logic [7:0]        wdata;
   } fsbc_bus_req_t;

   typedef struct packed {
      logic              done;
      logic              found;
      logic [7:0]        rdata;
      logic [7:0][7:0]   id;
   } fsbc_bus_rsp_t;

endpackage : fsbc_pkg

// >>> core/fsbc_cmd_core.sv
// command handler for fan reporting, fan power and the single wire sensor bus
// assumes a byte level bus engine outside, whole packets in and out, Avalon-MM host

module fsbc_cmd_core
   import fsbc_pkg::*;
#(
   parameter int unsigned SLOT_CYC = FSBC_SLOT_CYC // clocks per eighth second
) (
   input  wire logic                mclk,            // system clock
   input  wire logic                rstn,            // synchronous reset
   input  wire logic                cmd_valid,       // command packet offered
   input  wire fsbc_cmd_t           cmd,             // command packet
   output wire logic                cmd_ready,       // command packet taken
   output wire logic                rsp_valid,       // reply packet offered
   output wire fsbc_rsp_t           rsp,             // reply packet
   input  wire logic                rsp_ready,       // reply packet taken
   output wire fsbc_bus_req_t       bus_req,         // sensor bus operation
   input  wire fsbc_bus_rsp_t       bus_rsp,         // sensor bus completion
   input  wire logic [3:0][15:0]    fan_tach,        // measured fan speeds
   output wire logic [3:0][6:0]     fan_level,       // applied fan power
   input  wire logic [3:0][6:0]     boot_level_in,   // saved fan power
   output wire logic [3:0][6:0]     boot_level_out,  // fan power to save
   output wire logic                boot_save,       // save strobe
   output wire logic [31:0]         temp_mask,       // temperature report mask
   input  wire logic [3:0]          avs_address,     // register byte address
   input  wire logic                avs_read,        // register read
   input  wire logic                avs_write,       // register write
   input  wire logic [31:0]         avs_writedata,   // register write data
   output wire logic [31:0]         avs_readdata,    // register read data
   output wire logic                avs_waitrequest, // register stall
   output wire logic                irq              // interrupt level
);

   typedef struct packed {
      fsbc_state_t             st;
      logic [3:0]              fan_mask;
      logic [3:0][6:0]         fan_pwr;
      logic [3:0][6:0]         fan_level;
      logic [31:0]             temp_mask;
      logic [31:0][7:0][7:0]   ids;
      logic [5:0]              n_ids;
      logic [FSBC_TICK_W-1:0]  tick;
      logic [1:0]              slot;
      logic                    rep_pend;
      logic [1:0]              rep_fan;
      fsbc_bus_req_t           bus;
      logic [3:0]              cnt;
      logic [7:0]              x_idx;
      logic [3:0]              x_rcnt;
      logic [3:0]              x_wlen;
      logic [13:0][7:0]        x_data;
      logic                    cmd_ready;
      logic                    rsp_valid;
      fsbc_rsp_t               rsp;
      logic                    boot_save;
      logic                    waitreq;
      logic [31:0]             rdata;
      logic [3:0]              irq_st;
      logic [3:0]              irq_en;
      logic                    irq;
   } fsbc_core_t;

   fsbc_core_t   s;
   fsbc_core_t   n;
   logic         ok;
   logic         take;
   logic         lvl_ok;
   logic         use_adr;
   logic [3:0]   ev;
   logic [3:0]   clr;
   logic [1:0]   nslot;
   logic [31:0]  rd_mux;

   // ==========================================================
   // outputs
   assign cmd_ready       = s.cmd_ready;
   assign rsp_valid       = s.rsp_valid;
   assign rsp             = s.rsp;
   assign bus_req         = s.bus;
   assign fan_level       = s.fan_level;
   assign boot_level_out  = s.fan_pwr;
   assign boot_save       = s.boot_save;
   assign temp_mask       = s.temp_mask;
   assign avs_readdata    = s.rdata;
   assign avs_waitrequest = s.waitreq;
   assign irq             = s.irq;

   // ==========================================================
   // next state
   always_comb begin
      n       = s;
      ok      = 1'b0;
      take    = cmd_valid && s.cmd_ready;
      lvl_ok  = 1'b1;
      use_adr = (s.x_idx != FSBC_IDX_SKIP) && (s.x_idx < {2'h0, s.n_ids});
      ev      = 4'h0;
      clr     = 4'h0;
      nslot   = s.slot + 2'h1;
      n.boot_save = 1'b0;

      // register slave: one wait cycle, then the answer
      case (avs_address)
         FSBC_REG_STATUS: rd_mux = {28'h0, s.irq_st};
         FSBC_REG_IRQ_EN: rd_mux = {28'h0, s.irq_en};
         FSBC_REG_INFO:   rd_mux = {15'h0, s.n_ids, s.fan_mask, s.st};
         default:         rd_mux = 32'h0;
      endcase
      n.waitreq = 1'b1;
      if ((avs_read || avs_write) && s.waitreq) begin
         n.waitreq = 1'b0;
         n.rdata   = rd_mux;
      end
      if (avs_write && !s.waitreq) begin
         if (avs_address == FSBC_REG_IRQ_EN) begin
            n.irq_en = avs_writedata[3:0];
         end
         if (avs_address == FSBC_REG_IRQ_CLR) begin
            clr = avs_writedata[3:0];
         end
      end

      if (s.rsp_valid && rsp_ready) begin
         n.rsp_valid = 1'b0;
      end

      // eighth-second slots, one per fan
      if (s.tick == FSBC_TICK_W'(SLOT_CYC - 1)) begin
         n.tick = '0;
         n.slot = nslot;
         if (s.fan_mask[nslot]) begin
            n.rep_pend = 1'b1;
            n.rep_fan  = nslot;
         end
      end else begin
         n.tick = s.tick + FSBC_TICK_W'(1);
      end
      for (int i = 0; i < FSBC_FANS; i++) begin
         if (s.fan_mask[i] && (s.slot == 2'(i))) begin
            n.fan_level[i] = FSBC_LEVEL_FULL;
         end else begin
            n.fan_level[i] = s.fan_pwr[i];
         end
      end

      case (s.st)
         FSBC_S_INIT: begin
            n.fan_pwr = boot_level_in;
            n.st      = FSBC_S_ENUM;
         end

         FSBC_S_ENUM: begin
            if (!s.bus.req) begin
               n.bus.req   = 1'b1;
               n.bus.op    = (s.n_ids == 6'h0) ? FSBC_OP_FIRST : FSBC_OP_NEXT;
               n.bus.wdata = 8'h00;
            end else if (bus_rsp.done) begin
               n.bus.req = 1'b0;
               if (bus_rsp.found) begin
                  n.ids[s.n_ids[4:0]] = bus_rsp.id;
                  n.n_ids = s.n_ids + 6'h1;
               end
               if (!bus_rsp.found || (s.n_ids == 6'h1f)) begin
                  n.st = FSBC_S_IDLE;
                  ev[FSBC_EV_ENUM] = 1'b1;
               end
            end
         end

         FSBC_S_IDLE: begin
            if (take) begin
               n.rsp.rtype = cmd.ctype | FSBC_ACK_BIT;
               n.rsp.len   = FSBC_LEN_ZERO;
               n.rsp.data  = '0;
               case (cmd.ctype)
                  FSBC_CMD_STORE: begin
                     ok          = (cmd.len == FSBC_LEN_ZERO);
                     n.boot_save = ok;
                  end
                  FSBC_CMD_FAN_RPT: begin
                     ok = (cmd.len == FSBC_LEN_ONE) && (cmd.data[0] <= FSBC_FAN_MASK_MAX);
                     if (ok) begin
                        n.fan_mask = cmd.data[0][3:0];
                     end
                  end
                  FSBC_CMD_FAN_PWR: begin
                     for (int i = 0; i < FSBC_FANS; i++) begin
                        lvl_ok = lvl_ok && (cmd.data[i] <= FSBC_LEVEL_MAX);
                     end
                     ok = (cmd.len == FSBC_LEN_FOUR) && lvl_ok;
                     if (ok) begin
                        for (int i = 0; i < FSBC_FANS; i++) begin
                           n.fan_pwr[i] = cmd.data[i][6:0];
                        end
                     end
                  end
                  FSBC_CMD_DEV_INFO: begin
                     ok = (cmd.len == FSBC_LEN_ONE) && (cmd.data[0] <= FSBC_IDX_MAX);
                     if (ok) begin
                        n.rsp.len     = FSBC_LEN_INFO;
                        n.rsp.data[0] = cmd.data[0];
                        for (int j = 0; j < 8; j++) begin
                           n.rsp.data[j + 1] = s.ids[cmd.data[0][4:0]][j];
                        end
                     end
                  end
                  FSBC_CMD_TEMP_RPT: begin
                     ok = (cmd.len == FSBC_LEN_FOUR);
                     if (ok) begin
                        n.temp_mask = {cmd.data[3], cmd.data[2], cmd.data[1], cmd.data[0]};
                     end
                  end
                  FSBC_CMD_XACT: begin
                     ok = (cmd.len >= FSBC_XACT_MIN) && (cmd.len <= FSBC_XACT_MAX)
                        && (cmd.data[0] <= FSBC_IDX_SKIP) && (cmd.data[1] <= FSBC_RCNT_MAX)
                        && !((cmd.len == FSBC_XACT_MIN) && (cmd.data[1] == 8'h00));
                     if (ok) begin
                        n.x_idx  = cmd.data[0];
                        n.x_rcnt = cmd.data[1][3:0];
                        n.x_wlen = 4'(cmd.len - FSBC_XACT_MIN);
                        n.x_data = cmd.data[15:2];
                        n.st     = FSBC_S_XRST;
                     end
                  end
                  default: begin
                     ok = 1'b0;
                  end
               endcase
               if (!ok) begin
                  n.rsp.rtype = cmd.ctype | FSBC_ERR_BITS;
                  n.rsp.len   = FSBC_LEN_ZERO;
                  n.rsp.data  = '0;
                  n.rsp_valid = 1'b1;
                  ev[FSBC_EV_BAD] = 1'b1;
               end else if (cmd.ctype != FSBC_CMD_XACT) begin
                  n.rsp_valid = 1'b1;
                  ev[FSBC_EV_CMD] = 1'b1;
               end
            end else if (s.rep_pend && !s.rsp_valid) begin
               n.rsp_valid   = 1'b1;
               n.rsp.rtype   = FSBC_FAN_REPORT;
               n.rsp.len     = FSBC_LEN_FAN_RSP;
               n.rsp.data    = '0;
               n.rsp.data[0] = {6'h0, s.rep_fan};
               n.rsp.data[1] = fan_tach[s.rep_fan][15:8];
               n.rsp.data[2] = fan_tach[s.rep_fan][7:0];
               n.rep_pend    = 1'b0;
               ev[FSBC_EV_RPT] = 1'b1;
            end
         end

         FSBC_S_XRST: begin
            if (!s.bus.req) begin
               n.bus.req   = 1'b1;
               n.bus.op    = FSBC_OP_RESET;
               n.bus.wdata = 8'h00;
            end else if (bus_rsp.done) begin
               n.bus.req = 1'b0;
               n.cnt     = 4'h0;
               if (use_adr) begin
                  n.st = FSBC_S_XADR;
               end else if (s.x_wlen != 4'h0) begin
                  n.st = FSBC_S_XWR;
               end else begin
                  n.st = FSBC_S_XRD;
               end
            end
         end

         FSBC_S_XADR: begin
            if (!s.bus.req) begin
               n.bus.req = 1'b1;
               n.bus.op  = FSBC_OP_WRITE;
               if (s.cnt == 4'h0) begin
                  n.bus.wdata = FSBC_MATCH_CMD;
               end else begin
                  n.bus.wdata = s.ids[s.x_idx[4:0]][s.cnt[2:0] - 3'h1];
               end
            end else if (bus_rsp.done) begin
               n.bus.req = 1'b0;
               n.cnt     = s.cnt + 4'h1;
               if (s.cnt == 4'h8) begin
                  n.cnt = 4'h0;
                  if (s.x_wlen != 4'h0) begin
                     n.st = FSBC_S_XWR;
                  end else begin
                     n.st = FSBC_S_XRD;
                  end
               end
            end
         end

         FSBC_S_XWR: begin
            if (!s.bus.req) begin
               n.bus.req   = 1'b1;
               n.bus.op    = FSBC_OP_WRITE;
               n.bus.wdata = s.x_data[s.cnt];
            end else if (bus_rsp.done) begin
               n.bus.req = 1'b0;
               n.cnt     = s.cnt + 4'h1;
               if ((s.cnt + 4'h1) == s.x_wlen) begin
                  n.cnt = 4'h0;
                  n.st  = FSBC_S_XRD;
               end
            end
         end

         FSBC_S_XRD: begin
            if (s.x_rcnt == 4'h0) begin
               n.st        = FSBC_S_IDLE;
               n.rsp_valid = 1'b1;
               ev[FSBC_EV_CMD] = 1'b1;
            end else if (!s.bus.req) begin
               n.bus.req   = 1'b1;
               n.bus.op    = FSBC_OP_READ;
               n.bus.wdata = 8'h00;
            end else if (bus_rsp.done) begin
               n.bus.req          = 1'b0;
               n.rsp.data[s.cnt]  = bus_rsp.rdata;
               n.cnt              = s.cnt + 4'h1;
               if ((s.cnt + 4'h1) == s.x_rcnt) begin
                  n.st        = FSBC_S_IDLE;
                  n.rsp.len   = {1'b0, s.x_rcnt};
                  n.rsp_valid = 1'b1;
                  ev[FSBC_EV_CMD] = 1'b1;
               end
            end
         end

         default: begin
            n.st = FSBC_S_IDLE;
         end
      endcase

      // a new event wins over a clear in the same cycle
      n.irq_st    = (s.irq_st & ~clr) | ev;
      n.irq       = |(n.irq_st & n.irq_en);
      n.cmd_ready = (n.st == FSBC_S_IDLE) && !n.rsp_valid;
   end

   // ==========================================================
   // state register
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         s         <= '0;
         s.st      <= FSBC_S_INIT;
         s.waitreq <= 1'b1;
      end else begin
         s <= n;
      end
   end

endmodule : fsbc_cmd_core

// >>> testbench/fsbc_cmd_core_properties.sv
// port-level checker of the fan and sensor bus command block
// assumes it is bound into fsbc_cmd_core, one clock, synchronous low reset
module fsbc_cmd_props
   import fsbc_pkg::*;
(
   input wire logic            mclk, rstn, cmd_valid, cmd_ready, rsp_valid, rsp_ready, // handshakes
   input wire fsbc_cmd_t       cmd, // command packet
   input wire fsbc_rsp_t       rsp, // reply packet
   input wire fsbc_bus_req_t   bus_req, // bus operation
   input wire fsbc_bus_rsp_t   bus_rsp, // bus completion
   input wire logic [3:0][6:0] boot_level_out, // programmed power
   input wire logic            boot_save, avs_read, avs_write, avs_waitrequest // save and register bus
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);
   // ==========================================================
   // helpers
   logic             take;
   logic             pwr_ok;
   logic [3:0][6:0]  want;
   assign take = cmd_valid && cmd_ready;
   assign pwr_ok = take && cmd.ctype == FSBC_CMD_FAN_PWR && cmd.len == FSBC_LEN_FOUR && cmd.data[0] <= FSBC_LEVEL_MAX
                   && cmd.data[1] <= FSBC_LEVEL_MAX && cmd.data[2] <= FSBC_LEVEL_MAX && cmd.data[3] <= FSBC_LEVEL_MAX;
   always_ff @(posedge mclk) begin
      if (pwr_ok) begin
         want <= {cmd.data[3][6:0], cmd.data[2][6:0], cmd.data[1][6:0], cmd.data[0][6:0]};
      end
   end
   sequence s_reset_done;
      bus_rsp.done && bus_req.op == FSBC_OP_RESET;
   endsequence
   sequence s_next_phase;
      !bus_req.req ##1 (bus_req.req && bus_req.op inside {FSBC_OP_WRITE, FSBC_OP_READ});
   endsequence
   // ==========================================================
   // properties
   a_fan_ack: assert property (pwr_ok |=> rsp_valid && rsp.rtype == 8'h51 && rsp.len == FSBC_LEN_ZERO)
      else $error("fan power not acknowledged");
   a_level_kept: assert property (pwr_ok |=> ##1 boot_level_out == want)
      else $error("fan power not applied");
   a_mask_range: assert property (take && cmd.ctype == FSBC_CMD_FAN_RPT && cmd.data[0] > FSBC_FAN_MASK_MAX
      |=> rsp_valid && rsp.rtype == 8'hd0) else $error("bad fan mask accepted");
   a_xact_range: assert property (take && cmd.ctype == FSBC_CMD_XACT && (cmd.len < FSBC_XACT_MIN
      || cmd.len > FSBC_XACT_MAX || cmd.data[0] > FSBC_IDX_SKIP || cmd.data[1] > FSBC_RCNT_MAX
      || (cmd.len == FSBC_XACT_MIN && cmd.data[1] == 8'h00)) |=> rsp_valid && rsp.rtype == 8'hd4)
      else $error("bad transaction accepted");
   a_report_form: assert property (rsp_valid && rsp.rtype == FSBC_FAN_REPORT
      |-> rsp.len == FSBC_LEN_FAN_RSP && rsp.data[0] <= 8'h03) else $error("malformed fan report");
   a_store_save: assert property (take && cmd.ctype == FSBC_CMD_STORE && cmd.len == FSBC_LEN_ZERO
      |-> ##[1:2] boot_save) else $error("store gave no save strobe");
   a_save_pulse: assert property (boot_save |=> !boot_save) else $error("save strobe too long");
   a_phase_order: assert property (s_reset_done |=> s_next_phase) else $error("bad phase after bus reset");
   a_bus_hold: assert property (bus_req.req && !bus_rsp.done |=> bus_req.req && $stable(bus_req))
      else $error("bus request changed early");
   a_rsp_hold: assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp))
      else $error("reply dropped before accept");
   a_one_cmd: assert property (take |=> !cmd_ready) else $error("second command taken");
   a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
      else $error("register answer timing wrong");
endmodule : fsbc_cmd_props

bind fsbc_cmd_core fsbc_cmd_props u_props (.*);

// >>> testbench/fsbc_bus_model.sv
// behavioural single wire sensor bus engine with a few devices on it
// assumes the req and done handshake of the command block, logs every operation
module fsbc_bus_model
   import fsbc_pkg::*;
#(
   parameter int         NDEV = 2,    // devices found at enumeration
   parameter logic [7:0] FAM  = 8'h3c // family code, arbitrary value
) (
   input  wire logic          mclk,    // system clock
   input  wire logic          slow,    // long answer delay
   input  wire fsbc_bus_req_t bus_req, // operation from the block
   output var  fsbc_bus_rsp_t bus_rsp  // completion to the block
);
   logic [10:0] log_q[$];
   int          wt = 0;
   int          ecnt = 0;
   int          nrd = 0;
   int          e;
   initial bus_rsp = '0;
   always @(posedge mclk) begin
      if (bus_rsp.done) begin
         bus_rsp <= ~bus_rsp; // answer fields do not hold after the pulse
      end else if (bus_req.req) begin
         if (wt < (slow ? 6 : 0)) begin
            wt <= wt + 1;
         end else begin
            wt <= 0;
            log_q.push_back({bus_req.op, bus_req.op == FSBC_OP_WRITE ? bus_req.wdata : 8'h00});
            bus_rsp.done <= 1'b1;
            bus_rsp.found <= 1'b0;
            bus_rsp.rdata <= 8'ha0 + nrd[7:0];
            case (bus_req.op)
               FSBC_OP_RESET: nrd <= 0;
               FSBC_OP_READ: nrd <= nrd + 1;
               FSBC_OP_FIRST, FSBC_OP_NEXT: begin
                  e = (bus_req.op == FSBC_OP_FIRST) ? 0 : ecnt;
                  bus_rsp.found <= e < NDEV;
                  for (int i = 0; i < 8; i++) begin
                     bus_rsp.id[i] <= (i == 0) ? FAM : 8'(16 * e + i);
                  end
                  ecnt <= e + 1;
               end
               default: ;
            endcase
         end
      end
   end
endmodule : fsbc_bus_model

// >>> testbench/fsbc_cmd_core_tb.sv
// self-checking bench of the command block beside a bus engine model
// assumes fsbc_pkg, fsbc_bus_model and the checker compiled before it
module fsbc_cmd_core_tb import fsbc_pkg::*; ();
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk = 0, rstn = 0, cmd_valid = 0, rsp_ready = 0, slow = 0, avs_read = 0, avs_write = 0;
   logic irq, cmd_ready, rsp_valid, boot_save, avs_waitrequest;
   logic [3:0] avs_address = '0;
   logic [31:0] avs_writedata = '0, avs_readdata, temp_mask, q;
   fsbc_cmd_t cmd = '0;
   fsbc_rsp_t rsp, r;
   fsbc_bus_req_t bus_req;
   fsbc_bus_rsp_t bus_rsp;
   logic [3:0][15:0] fan_tach = {16'h4444, 16'h3333, 16'h2222, 16'h1111};
   logic [3:0][6:0] fan_level, boot_level_out, boot_level_in = {7'h04, 7'h03, 7'h02, 7'h01};
   logic [10:0] expq[$];
   int errors = 0, num_checks = 0, cyc = 0;
   always #50 mclk = ~mclk;
   always @(posedge mclk) cyc <= cyc + 1;
   fsbc_cmd_core #(.SLOT_CYC(40)) uut (.*);
   fsbc_bus_model far (.*);
   // ==========================================================
   // shared tasks
   task chk(input logic [63:0] got, input logic [63:0] exp);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task summarize();
      $display("errors=%0d num_checks=%0d", errors, num_checks);
      if (errors == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : summarize
   task get(input bit skip);
      int k;
      k = 0;
      do begin
         do begin @(posedge mclk); k++; end while (rsp_valid !== 1'b1 && k < 5000);
         r = rsp;
         rsp_ready <= 1'b1;
         @(posedge mclk);
         rsp_ready <= 1'b0;
      end while (skip && r.rtype === FSBC_FAN_REPORT && k < 5000);
   endtask : get
   task send(input logic [7:0] t, input logic [4:0] n, input logic [127:0] d);
      int k;
      k = 0;
      @(posedge mclk);
      cmd_valid <= 1'b1;
      cmd <= {t, n, d};
      // drain fan reports that would otherwise keep the command side blocked
      do begin @(posedge mclk); k++; rsp_ready <= rsp_valid; end while (cmd_ready !== 1'b1 && k < 5000);
      cmd_valid <= 1'b0;
      get(1'b1);
   endtask : send
   task av(input bit wr, input logic [3:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge mclk);
      avs_read <= !wr;
      avs_write <= wr;
      avs_address <= a;
      avs_writedata <= d;
      do begin @(posedge mclk); k++; end while (avs_waitrequest !== 1'b0 && k < 100);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask : av
   task xact(input logic [7:0] idx, input logic [7:0] rc, input logic [4:0] n, input logic [15:0] w);
      far.log_q.delete();
      send(FSBC_CMD_XACT, n, {w, rc, idx});
      chk(r.rtype, 8'h54);
      chk(r.len, rc[4:0]);
      expq = {{FSBC_OP_RESET, 8'h00}};
      if (idx == 8'h01) expq.push_back({FSBC_OP_WRITE, FSBC_MATCH_CMD});
      for (int i = 0; i < 8 && idx == 8'h01; i++) expq.push_back({FSBC_OP_WRITE, 8'(i == 0 ? 8'h3c : 8'h10 + i)});
      for (int i = 2; i < n; i++) expq.push_back({FSBC_OP_WRITE, w[8 * (i - 2) +: 8]});
      for (int i = 0; i < rc; i++) expq.push_back({FSBC_OP_READ, 8'h00});
      for (int i = 0; i < rc; i++) chk(r.data[i], 8'ha0 + i);
      chk(far.log_q.size(), expq.size());
      foreach (expq[i]) chk(far.log_q[i], expq[i]);
   endtask : xact
   // ==========================================================
   // scenarios
   task t_boot();
      repeat (400) @(posedge mclk);
      chk(boot_level_out, boot_level_in);
      av(1'b0, FSBC_REG_INFO, '0);
      chk(q, {15'h0, 6'h02, 4'h0, 7'h04});
   endtask : t_boot
   task t_power();
      send(FSBC_CMD_FAN_PWR, 5'h04, {8'h64, 8'h00, 8'h14, 8'h0a});
      chk(r.rtype, 8'h51);
      repeat (2) @(posedge mclk);
      chk(boot_level_out, {7'h64, 7'h00, 7'h14, 7'h0a});
      send(FSBC_CMD_FAN_PWR, 5'h04, {8'h00, 8'h65, 8'h00, 8'h00});
      chk(r.rtype, 8'hd1);
      send(FSBC_CMD_STORE, 5'h00, '0);
      chk(r.rtype, 8'h44);
   endtask : t_power
   task t_info();
      send(FSBC_CMD_DEV_INFO, 5'h01, 8'h01);
      chk({r.len, r.data[0]}, {5'h09, 8'h01});
      chk(r.data[8:1], 64'h171615141312113c);
      send(FSBC_CMD_DEV_INFO, 5'h01, 8'h20);
      chk(r.rtype, 8'hd2);
      send(FSBC_CMD_TEMP_RPT, 5'h04, 32'h80000102);
      chk(r.rtype, 8'h53);
      chk(temp_mask, 32'h80000102);
   endtask : t_info
   task t_xact();
      slow <= 1'b1;
      xact(8'h01, 8'h02, 5'h04, 16'hbecc);
      slow <= 1'b0;
      xact(8'h20, 8'h01, 5'h02, 16'h0000);
      xact(8'h05, 8'h00, 5'h03, 16'h0077);
      send(FSBC_CMD_XACT, 5'h02, 32'h0020);
      chk(r.rtype, 8'hd4);
      send(FSBC_CMD_XACT, 5'h02, 32'h0121);
      chk(r.rtype, 8'hd4);
      send(FSBC_CMD_XACT, 5'h11, 32'h0f20);
      chk(r.rtype, 8'hd4);
   endtask : t_xact
   task t_regs();
      av(1'b0, FSBC_REG_STATUS, '0);
      chk(q, 32'h0000000b);
      av(1'b1, FSBC_REG_IRQ_EN, 32'h8);
      av(1'b0, FSBC_REG_IRQ_EN, '0);
      chk({q, 31'h0, irq}, {32'h8, 32'h1});
      av(1'b1, FSBC_REG_IRQ_CLR, 32'h8);
      av(1'b1, FSBC_REG_STATUS, 32'hf);
      av(1'b0, FSBC_REG_STATUS, '0);
      chk({q, 31'h0, irq}, {32'h3, 32'h0});
      av(1'b0, 4'h2, '0);
      chk(q, 32'h0);
   endtask : t_regs
   task t_fan();
      int t0, n0, n1;
      send(FSBC_CMD_FAN_RPT, 5'h01, 8'h10);
      chk(r.rtype, 8'hd0);
      send(FSBC_CMD_FAN_RPT, 5'h01, 8'h05);
      chk(r.rtype, 8'h50);
      for (int i = 0; i < 4; i++) begin
         get(1'b0);
         chk({r.rtype, r.len, r.data[0][7:2], r.data[0][0]}, {8'h81, 5'h03, 7'h0});
         chk({r.data[1], r.data[2]}, fan_tach[r.data[0][1:0]]);
         if (i > 0) chk(cyc - t0, 80);
         t0 = cyc;
      end
      n0 = 0;
      n1 = 0;
      repeat (160) begin
         @(posedge mclk);
         n0 += (fan_level[0] === 7'h64);
         n1 += (fan_level[1] === 7'h14);
      end
      chk({n0, n1}, {32'd40, 32'd160});
      send(FSBC_CMD_FAN_RPT, 5'h01, 8'h00);
   endtask : t_fan
   initial begin
      repeat (20) @(posedge mclk);
      rstn <= 1'b1;
      t_boot();
      t_power();
      t_info();
      t_xact();
      t_regs();
      t_fan();
      summarize();
   end
   initial begin
      repeat (30000) @(posedge mclk);
      errors++;
      summarize();
   end
endmodule : fsbc_cmd_core_tb
